// ### hw/grdb_top.sv
`include "grdb_params.svh"
`default_nettype none
module grdb_top (
   input wire logic aclk,
   input wire logic aresetn,
   input wire grdb_pkg::grdb_axi_req_t axi_req,
   output grdb_pkg::grdb_axi_rsp_t axi_rsp,
   input wire grdb_pkg::grdb_cmd_t cmd,
   output logic cmd_ready,
   output logic [3:0] cpu_rdata,
   output grdb_pkg::grdb_pbus_t pbus,
   input wire logic [7:0] periph_rdata,
   output logic rom_re,
   output logic [13:0] rom_addr,
   input wire logic [15:0] rom_data
);
   import grdb_pkg::*;
   localparam int NMEM = `GRDB_MEM_NIBS;
   localparam int NSR = `GRDB_SR_NUM;
   localparam logic [15:0] XB_RST = `GRDB_XBUF_RESET;
   localparam logic [8:0] XBI = `GRDB_XBUF_IDX;
   localparam logic [6:0] SYS = `GRDB_SYS_BASE;

   grdb_nib_t mem [NMEM];
   grdb_nib_t next_mem [NMEM];
   grdb_nib_t sr [NSR];
   grdb_nib_t next_sr [NSR];
   grdb_seq_t seq, next_seq;
   logic next_cmd_ready;
   logic [3:0] next_cpu_rdata;
   grdb_pbus_t next_pbus;
   logic next_rom_re;
   logic [13:0] next_rom_addr;
   logic cmd_go;
   logic [1:0] m_bank, w_bank;
   logic [6:0] w_addr;
   logic m_sys, w_sys;
   logic [3:0] m_sidx, w_sidx;
   grdb_nib_t m_val, w_val, alu_y;
   logic alu_c;
   logic [15:0] xbuf;
   logic [13:0] tadr;
   logic c_wen;
   logic [1:0] c_bank;
   logic [6:0] c_addr;
   grdb_nib_t c_data;
   logic psw_wen;
   logic [3:0] xb_wen;
   logic [15:0] xb_data;
   logic ta_wen;
   logic wr_req, wr_ack, wr_err, rd_err;
   logic [11:0] wr_addr, rd_addr;
   logic [31:0] wr_data, rd_data;
   logic [3:0] wr_strb;
   logic a_sys, r_sys;
   logic [3:0] a_sidx, r_sidx;

   // Slots whose upper two bits do not exist always hold zero there
   function automatic logic [3:0] sr_mask(input logic [3:0] idx);
      logic [3:0] m;
      m = 4'hF;
      if (idx == `GRDB_SR_TADR3 || idx == `GRDB_SR_WPH ||
          idx == `GRDB_SR_BANK) begin
         m = `GRDB_NARROW_MASK;
      end
      return m;
   endfunction : sr_mask

   // Addressed operand uses the bank register, window uses its pointer
   assign cmd_go = cmd.valid && cmd_ready;
   assign m_bank = sr[`GRDB_SR_BANK][1:0];
   assign m_sys = cmd.addr >= SYS;
   assign m_sidx = 4'(cmd.addr - SYS);
   assign m_val = m_sys ? sr[m_sidx] : mem[{m_bank, cmd.addr}];
   assign w_bank = sr[`GRDB_SR_WPH][1:0];
   assign w_addr = {sr[`GRDB_SR_WPL][3:1], cmd.col};
   assign w_sys = w_addr >= SYS;
   assign w_sidx = 4'(w_addr - SYS);
   assign w_val = w_sys ? sr[w_sidx] : mem[{w_bank, w_addr}];

   // Buffer is an ordinary bank-0 row slice, nibble 0 lowest
   assign xbuf = {mem[XBI + 9'h003], mem[XBI + 9'h002],
                  mem[XBI + 9'h001], mem[XBI]};
   assign tadr = {sr[`GRDB_SR_TADR3][1:0], sr[`GRDB_SR_TADR2],
                  sr[`GRDB_SR_TADR1], sr[`GRDB_SR_TADR0]};

   grdb_alu u_alu (
      .op(cmd.op),
      .a(w_val),
      .b(m_val),
      .y(alu_y),
      .c(alu_c)
   );

   // Instruction sequencer; only peripheral reads and table fetch wait
   always_comb begin
      next_seq = seq;
      next_pbus = pbus;
      next_pbus.we = 1'b0;
      next_pbus.re = 1'b0;
      next_rom_re = 1'b0;
      next_rom_addr = rom_addr;
      next_cpu_rdata = cpu_rdata;
      c_wen = 1'b0;
      c_bank = m_bank;
      c_addr = cmd.addr;
      c_data = cmd.imm;
      psw_wen = 1'b0;
      xb_wen = 4'h0;
      xb_data = xbuf;
      ta_wen = 1'b0;
      unique case (seq)
         SEQ_IDLE: begin
            if (cmd_go) begin
               unique case (cmd.op)
                  OP_NOP: begin
                  end
                  OP_MEM_RD: begin
                     next_cpu_rdata = m_val;
                  end
                  OP_MEM_WR: begin
                     c_wen = 1'b1;
                  end
                  OP_LOAD: begin
                     c_wen = 1'b1;
                     c_bank = w_bank;
                     c_addr = w_addr;
                     c_data = m_val;
                     next_cpu_rdata = m_val;
                  end
                  OP_STORE: begin
                     c_wen = 1'b1;
                     c_data = w_val;
                     next_cpu_rdata = w_val;
                  end
                  OP_ADD, OP_SUB, OP_AND, OP_OR, OP_XOR: begin
                     c_wen = 1'b1;
                     c_bank = w_bank;
                     c_addr = w_addr;
                     c_data = alu_y;
                     psw_wen = (cmd.op == OP_ADD) || (cmd.op == OP_SUB);
                     next_cpu_rdata = alu_y;
                  end
                  OP_PUT: begin
                     case (cmd.paddr)
                        `GRDB_PA_CLL, `GRDB_PA_CLH, `GRDB_PA_TRLD: begin
                           next_pbus.we = 1'b1;
                           next_pbus.addr = cmd.paddr;
                           next_pbus.wdata = xbuf[7:0];
                        end
                        `GRDB_PA_TADR: begin
                           ta_wen = 1'b1;
                        end
                        // Counter is read-only; unused addresses also
                        // take the write without effect
                        default: begin
                        end
                     endcase
                  end
                  OP_GET: begin
                     case (cmd.paddr)
                        `GRDB_PA_CLL, `GRDB_PA_CLH, `GRDB_PA_TCNT: begin
                           next_pbus.re = 1'b1;
                           next_pbus.addr = cmd.paddr;
                           next_seq = SEQ_GET;
                        end
                        `GRDB_PA_TADR: begin
                           xb_wen = 4'hF;
                           xb_data = {2'b00, tadr};
                        end
                        // Reload is write-only: buffer keeps its value
                        default: begin
                        end
                     endcase
                  end
                  OP_MOVT: begin
                     next_rom_re = 1'b1;
                     next_rom_addr = tadr;
                     next_seq = SEQ_MOVT;
                  end
                  default: begin
                  end
               endcase
            end
         end
         SEQ_GET: begin
            xb_wen = 4'h3;
            xb_data = {xbuf[15:8], periph_rdata};
            next_seq = SEQ_IDLE;
         end
         SEQ_MOVT: begin
            xb_wen = 4'hF;
            xb_data = rom_data;
            next_seq = SEQ_IDLE;
         end
      endcase
      next_cmd_ready = next_seq == SEQ_IDLE;
   end

   // Software writes only in cycles the core leaves the memory alone,
   // so a busy core can starve the bus for as long as it issues
   assign wr_ack = wr_req && !cmd_go && (seq == SEQ_IDLE);
   assign wr_err = !(wr_addr == `GRDB_OFS_XBUF ||
                     wr_addr == `GRDB_OFS_WP ||
                     (wr_addr[11] && wr_addr[1:0] == 2'b00));
   assign a_sys = wr_addr[8:2] >= SYS;
   assign a_sidx = 4'(wr_addr[8:2] - SYS);

   // Memory and control register update
   always_comb begin
      next_mem = mem;
      next_sr = sr;
      if (wr_ack && !wr_err) begin
         if (wr_addr == `GRDB_OFS_XBUF) begin
            for (int k = 0; k < 4; k++) begin
               if (wr_strb[k / 2]) begin
                  next_mem[XBI + 9'(k)] = wr_data[4 * k +: 4];
               end
            end
         end else if (wr_addr == `GRDB_OFS_WP) begin
            if (wr_strb[0]) begin
               next_sr[`GRDB_SR_WPL] = wr_data[3:0];
               next_sr[`GRDB_SR_WPH] = wr_data[7:4] &
                  sr_mask(`GRDB_SR_WPH);
            end
         end else if (wr_strb[0]) begin
            if (a_sys) begin
               next_sr[a_sidx] = wr_data[3:0] & sr_mask(a_sidx);
            end else begin
               next_mem[wr_addr[10:2]] = wr_data[3:0];
            end
         end
      end
      if (c_wen) begin
         if (c_addr >= SYS) begin
            next_sr[4'(c_addr - SYS)] = c_data &
               sr_mask(4'(c_addr - SYS));
         end else begin
            next_mem[{c_bank, c_addr}] = c_data;
         end
      end
      if (psw_wen) begin
         next_sr[`GRDB_SR_PSW][`GRDB_PSW_CY] = alu_c;
         next_sr[`GRDB_SR_PSW][`GRDB_PSW_Z] = alu_y == 4'h0;
      end
      for (int k = 0; k < 4; k++) begin
         if (xb_wen[k]) begin
            next_mem[XBI + 9'(k)] = xb_data[4 * k +: 4];
         end
      end
      if (ta_wen) begin
         next_sr[`GRDB_SR_TADR0] = xbuf[3:0];
         next_sr[`GRDB_SR_TADR1] = xbuf[7:4];
         next_sr[`GRDB_SR_TADR2] = xbuf[11:8];
         next_sr[`GRDB_SR_TADR3] = xbuf[15:12] &
            `GRDB_NARROW_MASK;
      end
   end

   // Register read decode
   assign r_sys = rd_addr[8:2] >= SYS;
   assign r_sidx = 4'(rd_addr[8:2] - SYS);
   always_comb begin
      rd_err = 1'b0;
      rd_data = 32'h0;
      if (rd_addr == `GRDB_OFS_XBUF) begin
         rd_data = {16'h0000, xbuf};
      end else if (rd_addr == `GRDB_OFS_WP) begin
         rd_data = {24'h000000, sr[`GRDB_SR_WPH], sr[`GRDB_SR_WPL]};
      end else if (rd_addr == `GRDB_OFS_STAT) begin
         rd_data = {23'h0, !cmd_ready, 3'h0, w_bank,
                    sr[`GRDB_SR_WPL][3:1]};
      end else if (rd_addr[11] && rd_addr[1:0] == 2'b00) begin
         rd_data = {28'h0, r_sys ? sr[r_sidx] : mem[rd_addr[10:2]]};
      end else begin
         rd_err = 1'b1;
      end
   end

   grdb_axil_slave u_axil (
      .aclk(aclk),
      .aresetn(aresetn),
      .axi_req(axi_req),
      .axi_rsp(axi_rsp),
      .wr_req(wr_req),
      .wr_addr(wr_addr),
      .wr_data(wr_data),
      .wr_strb(wr_strb),
      .wr_ack(wr_ack),
      .wr_err(wr_err),
      .rd_addr(rd_addr),
      .rd_data(rd_data),
      .rd_err(rd_err)
   );

   // State registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         seq <= SEQ_IDLE;
         cmd_ready <= 1'b1;
         cpu_rdata <= 4'h0;
         pbus <= '0;
         rom_re <= 1'b0;
         rom_addr <= 14'h0000;
         for (int i = 0; i < NSR; i++) begin
            sr[i] <= `GRDB_SR_RESET;
         end
         for (int i = 0; i < NMEM; i++) begin
            mem[i] <= 4'h0;
         end
         for (int k = 0; k < 4; k++) begin
            mem[XBI + 9'(k)] <= XB_RST[4 * k +: 4];
         end
      end else begin
         seq <= next_seq;
         cmd_ready <= next_cmd_ready;
         cpu_rdata <= next_cpu_rdata;
         pbus <= next_pbus;
         rom_re <= next_rom_re;
         rom_addr <= next_rom_addr;
         sr <= next_sr;
         mem <= next_mem;
      end
   end
endmodule : grdb_top
`default_nettype wire

// ### hw/grdb_params.svh
`ifndef GRDB_PARAMS_SVH
`define GRDB_PARAMS_SVH

// Storage geometry
`define GRDB_MEM_NIBS 512
`define GRDB_SR_NUM 12
`define GRDB_SYS_BASE 7'h74
`define GRDB_XBUF_IDX 9'h00C
`define GRDB_XBUF_RESET 16'h0320
`define GRDB_SR_RESET 4'h0

// Core control register slots, counted from the system base
`define GRDB_SR_TADR3 4'h0
`define GRDB_SR_TADR2 4'h1
`define GRDB_SR_TADR1 4'h2
`define GRDB_SR_TADR0 4'h3
`define GRDB_SR_BANK 4'h5
`define GRDB_SR_WPH 4'h9
`define GRDB_SR_WPL 4'hA
`define GRDB_SR_PSW 4'hB
`define GRDB_NARROW_MASK 4'h3
`define GRDB_PSW_CY 2
`define GRDB_PSW_Z 1

// Peripheral addresses
`define GRDB_PA_CLL 7'h03
`define GRDB_PA_CLH 7'h04
`define GRDB_PA_TCNT 7'h05
`define GRDB_PA_TRLD 7'h06
`define GRDB_PA_TADR 7'h40

// Bus map, byte addresses
`define GRDB_OFS_XBUF 12'h00C
`define GRDB_OFS_WP 12'h010
`define GRDB_OFS_STAT 12'h014
`define GRDB_RESP_OK 2'b00
`define GRDB_RESP_SLVERR 2'b10

`endif

// ### hw/grdb_pkg.sv
`default_nettype none
package grdb_pkg;
   typedef logic [3:0] grdb_nib_t;
   typedef enum logic [3:0] {
      OP_NOP, OP_MEM_RD, OP_MEM_WR, OP_LOAD, OP_STORE, OP_ADD, OP_SUB,
      OP_AND, OP_OR, OP_XOR, OP_PUT, OP_GET, OP_MOVT
   } grdb_op_t;
   typedef enum logic [1:0] {SEQ_IDLE, SEQ_GET, SEQ_MOVT} grdb_seq_t;
   typedef struct packed {
      logic valid;
      grdb_op_t op;
      logic [6:0] addr;
      logic [3:0] col;
      logic [3:0] imm;
      logic [6:0] paddr;
   } grdb_cmd_t;
   typedef struct packed {
      logic we;
      logic re;
      logic [6:0] addr;
      logic [7:0] wdata;
   } grdb_pbus_t;
   typedef struct packed {
      logic [11:0] awaddr;
      logic awvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic wvalid;
      logic bready;
      logic [11:0] araddr;
      logic arvalid;
      logic rready;
   } grdb_axi_req_t;
   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } grdb_axi_rsp_t;
endpackage : grdb_pkg
`default_nettype wire

// ### hw/grdb_alu.sv
`default_nettype none
module grdb_alu (
   input wire grdb_pkg::grdb_op_t op,
   input wire logic [3:0] a,
   input wire logic [3:0] b,
   output logic [3:0] y,
   output logic c
);
   import grdb_pkg::*;
   logic [4:0] sum;

   // Nibble arithmetic, carry doubles as borrow on subtract
   always_comb begin
      sum = 5'h00;
      unique case (op)
         OP_ADD: sum = {1'b0, a} + {1'b0, b};
         OP_SUB: sum = {1'b0, a} - {1'b0, b};
         OP_AND: sum = {1'b0, a & b};
         OP_OR: sum = {1'b0, a | b};
         OP_XOR: sum = {1'b0, a ^ b};
         default: sum = {1'b0, b};
      endcase
      y = sum[3:0];
      c = sum[4];
   end
endmodule : grdb_alu
`default_nettype wire

// ### hw/grdb_axil_slave.sv
`include "grdb_params.svh"
`default_nettype none
module grdb_axil_slave (
   input wire logic aclk,
   input wire logic aresetn,
   input wire grdb_pkg::grdb_axi_req_t axi_req,
   output grdb_pkg::grdb_axi_rsp_t axi_rsp,
   output logic wr_req,
   output logic [11:0] wr_addr,
   output logic [31:0] wr_data,
   output logic [3:0] wr_strb,
   input wire logic wr_ack,
   input wire logic wr_err,
   output logic [11:0] rd_addr,
   input wire logic [31:0] rd_data,
   input wire logic rd_err
);
   import grdb_pkg::*;
   grdb_axi_rsp_t next_rsp;
   logic aw_held, next_aw_held, w_held, next_w_held, ar_pend, next_ar_pend;
   logic [11:0] next_wr_addr, next_rd_addr;
   logic [31:0] next_wr_data;
   logic [3:0] next_wr_strb;

   // Write waits for both halves, in either order
   assign wr_req = aw_held && w_held;

   // Channel handshakes; readies are registered from the next state
   always_comb begin
      next_rsp = axi_rsp;
      next_aw_held = aw_held;
      next_w_held = w_held;
      next_ar_pend = ar_pend;
      next_wr_addr = wr_addr;
      next_wr_data = wr_data;
      next_wr_strb = wr_strb;
      next_rd_addr = rd_addr;
      if (axi_req.awvalid && axi_rsp.awready) begin
         next_aw_held = 1'b1;
         next_wr_addr = axi_req.awaddr;
      end
      if (axi_req.wvalid && axi_rsp.wready) begin
         next_w_held = 1'b1;
         next_wr_data = axi_req.wdata;
         next_wr_strb = axi_req.wstrb;
      end
      if (wr_req && wr_ack) begin
         next_aw_held = 1'b0;
         next_w_held = 1'b0;
         next_rsp.bvalid = 1'b1;
         next_rsp.bresp = wr_err ? `GRDB_RESP_SLVERR : `GRDB_RESP_OK;
      end
      if (axi_rsp.bvalid && axi_req.bready) begin
         next_rsp.bvalid = 1'b0;
      end
      if (axi_req.arvalid && axi_rsp.arready) begin
         next_ar_pend = 1'b1;
         next_rd_addr = axi_req.araddr;
      end
      if (ar_pend) begin
         next_ar_pend = 1'b0;
         next_rsp.rvalid = 1'b1;
         next_rsp.rdata = rd_data;
         next_rsp.rresp = rd_err ? `GRDB_RESP_SLVERR : `GRDB_RESP_OK;
      end
      if (axi_rsp.rvalid && axi_req.rready) begin
         next_rsp.rvalid = 1'b0;
      end
      next_rsp.awready = !next_aw_held && !next_rsp.bvalid;
      next_rsp.wready = !next_w_held && !next_rsp.bvalid;
      next_rsp.arready = !next_ar_pend && !next_rsp.rvalid;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         axi_rsp <= '0;
         aw_held <= 1'b0;
         w_held <= 1'b0;
         ar_pend <= 1'b0;
         wr_addr <= 12'h000;
         wr_data <= 32'h0;
         wr_strb <= 4'h0;
         rd_addr <= 12'h000;
      end else begin
         axi_rsp <= next_rsp;
         aw_held <= next_aw_held;
         w_held <= next_w_held;
         ar_pend <= next_ar_pend;
         wr_addr <= next_wr_addr;
         wr_data <= next_wr_data;
         wr_strb <= next_wr_strb;
         rd_addr <= next_rd_addr;
      end
   end
endmodule : grdb_axil_slave
`default_nettype wire

// ### testbench/grdb_periph_model.sv
`default_nettype none
module grdb_periph_model #(
   parameter logic [7:0] CNT_VAL = 8'h5C,
   parameter logic [15:0] ROM_KEY = 16'hC0DE
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire grdb_pkg::grdb_pbus_t pbus,
   output logic [7:0] periph_rdata,
   input wire logic rom_re,
   input wire logic [13:0] rom_addr,
   output logic [15:0] rom_data
);
   import grdb_pkg::*;
   logic [7:0] low_rld, high_rld, tmr_rld, junk, v;
   // Write strobes land here; the counter has no write path
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         low_rld <= 8'h00;
         high_rld <= 8'h00;
         tmr_rld <= 8'h00;
         junk <= 8'h00;
      end else begin
         junk <= junk + 8'h3B; // Idle bus must not look stable
         if (pbus.we) begin
            case (pbus.addr)
               7'h03: low_rld <= pbus.wdata;
               7'h04: high_rld <= pbus.wdata;
               7'h06: tmr_rld <= pbus.wdata;
               default: ;
            endcase
         end
      end
   end
   // Read data only while strobed, so a late sample sees garbage
   always_comb begin
      case (pbus.addr)
         7'h03: v = low_rld;
         7'h04: v = high_rld;
         7'h05: v = CNT_VAL;
         default: v = ~junk;
      endcase
      periph_rdata = pbus.re ? v : junk;
      rom_data = rom_re ? (ROM_KEY ^ {2'b00, rom_addr}) : {junk, ~junk};
   end
endmodule : grdb_periph_model
`default_nettype wire

// ### testbench/grdb_top_asserts.sv
`default_nettype none
module grdb_top_asserts (
   input wire logic aclk,
   input wire logic aresetn,
   input wire grdb_pkg::grdb_axi_req_t axi_req,
   input wire grdb_pkg::grdb_axi_rsp_t axi_rsp,
   input wire grdb_pkg::grdb_cmd_t cmd,
   input wire logic cmd_ready,
   input wire logic [3:0] cpu_rdata,
   input wire grdb_pkg::grdb_pbus_t pbus,
   input wire logic [7:0] periph_rdata,
   input wire logic rom_re,
   input wire logic [13:0] rom_addr,
   input wire logic [15:0] rom_data
);
   import grdb_pkg::*;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic go, ext_get, put_ok;
   // Accepted command decode
   assign go = cmd.valid && cmd_ready;
   assign ext_get = go && cmd.op == OP_GET &&
      cmd.paddr inside {7'h03, 7'h04, 7'h05};
   assign put_ok = go && cmd.op == OP_PUT &&
      cmd.paddr inside {7'h03, 7'h04, 7'h06};
   get_strobe_a: assert property (ext_get |=> pbus.re &&
      pbus.addr == $past(cmd.paddr)) else $error("get strobe wrong");
   get_stall_a: assert property (ext_get |=> !cmd_ready ##1 cmd_ready)
      else $error("get stall length wrong");
   put_strobe_a: assert property (put_ok |=> pbus.we &&
      pbus.addr == $past(cmd.paddr)) else $error("put strobe wrong");
   put_counter_a: assert property (
      go && cmd.op == OP_PUT && cmd.paddr == 7'h05 |=> !pbus.we)
      else $error("counter was written");
   get_reload_a: assert property (
      go && cmd.op == OP_GET && cmd.paddr == 7'h06 |=> !pbus.re)
      else $error("reload was read");
   table_fetch_a: assert property (go && cmd.op == OP_MOVT |=>
      rom_re ##1 (!rom_re && cmd_ready)) else $error("fetch wrong");
   addr_get_a: assert property (
      go && cmd.op == OP_GET && cmd.paddr == 7'h40 |=> !pbus.re && cmd_ready)
      else $error("address read stalled");
   window_op_a: assert property (go &&
      cmd.op inside {OP_LOAD, OP_STORE, OP_ADD, OP_SUB, OP_XOR} |=> cmd_ready)
      else $error("window op took extra cycle");
   cover property (ext_get);
   cover property (go && cmd.op == OP_MOVT);
   cover property (axi_rsp.bvalid && axi_rsp.bresp == 2'b10);
endmodule : grdb_top_asserts
bind grdb_top grdb_top_asserts u_chk (.aclk(aclk), .aresetn(aresetn),
   .axi_req(axi_req), .axi_rsp(axi_rsp), .cmd(cmd), .cmd_ready(cmd_ready),
   .cpu_rdata(cpu_rdata), .pbus(pbus), .periph_rdata(periph_rdata),
   .rom_re(rom_re), .rom_addr(rom_addr), .rom_data(rom_data));
`default_nettype wire

// ### testbench/tb_general_register_and_data_buffer.sv
`default_nettype none
module tb_general_register_and_data_buffer;
   timeunit 1ns;
   timeprecision 1ps;
   import grdb_pkg::*;
   localparam logic [7:0] CNT = 8'h5C;
   localparam logic [15:0] KEY = 16'hC0DE;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   grdb_axi_req_t req = '0;
   grdb_axi_rsp_t rsp;
   grdb_cmd_t cmd = '0;
   grdb_pbus_t pbus;
   logic cmd_ready, rom_re;
   logic [3:0] cpu_rdata;
   logic [7:0] periph_rdata;
   logic [13:0] rom_addr;
   logic [15:0] rom_data;
   int error_cnt = 0;
   int compares = 0;
   int cyc = 0;
   always #2.5 aclk = ~aclk;
   grdb_top dut (.aclk(aclk), .aresetn(aresetn), .axi_req(req),
      .axi_rsp(rsp), .cmd(cmd), .cmd_ready(cmd_ready),
      .cpu_rdata(cpu_rdata), .pbus(pbus), .periph_rdata(periph_rdata),
      .rom_re(rom_re), .rom_addr(rom_addr), .rom_data(rom_data));
   grdb_periph_model #(.CNT_VAL(CNT), .ROM_KEY(KEY)) u_per (.aclk(aclk),
      .aresetn(aresetn), .pbus(pbus), .periph_rdata(periph_rdata),
      .rom_re(rom_re), .rom_addr(rom_addr), .rom_data(rom_data));
   task automatic wrap_up();
      $display("Compares %0d, errors %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : wrap_up
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error t=%0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // One AXI transfer; readies are looked at mid-cycle to avoid edge races
   task automatic axi(input logic wr, input logic [11:0] a,
      input logic [31:0] d, input logic [3:0] s,
      output logic [31:0] rd, output logic [1:0] rs);
      logic aw, w, ta, tw;
      @(posedge aclk);
      aw = wr;
      w = wr;
      rd = '0;
      if (wr) begin
         req.awaddr <= a;
         req.awvalid <= 1'b1;
         req.wdata <= d;
         req.wstrb <= s;
         req.wvalid <= 1'b1;
         while (aw || w) begin
            @(negedge aclk);
            ta = aw && rsp.awready;
            tw = w && rsp.wready;
            @(posedge aclk);
            if (ta) aw = 1'b0;
            if (tw) w = 1'b0;
            if (ta) req.awvalid <= 1'b0;
            if (tw) req.wvalid <= 1'b0;
         end
         req.bready <= 1'b1;
         @(negedge aclk);
         while (!rsp.bvalid) @(negedge aclk);
         rs = rsp.bresp;
         @(posedge aclk);
         req.bready <= 1'b0;
      end else begin
         req.araddr <= a;
         req.arvalid <= 1'b1;
         @(negedge aclk);
         while (!rsp.arready) @(negedge aclk);
         @(posedge aclk);
         req.arvalid <= 1'b0;
         req.rready <= 1'b1;
         @(negedge aclk);
         while (!rsp.rvalid) @(negedge aclk);
         rd = rsp.rdata;
         rs = rsp.rresp;
         @(posedge aclk);
         req.rready <= 1'b0;
      end
   endtask : axi
   task automatic wrc(input logic [11:0] a, input logic [31:0] d,
      input logic [3:0] s);
      logic [31:0] x;
      logic [1:0] r;
      axi(1'b1, a, d, s, x, r);
      chk(r, 2'b00);
   endtask : wrc
   task automatic rdc(input logic [11:0] a, input logic [31:0] e);
      logic [31:0] x;
      logic [1:0] r;
      axi(1'b0, a, 32'h0, 4'h0, x, r);
      chk({r, x[29:0]}, {2'b00, e[29:0]});
   endtask : rdc
   // Core command; held until an edge sees cmd_ready high
   task automatic cpu(input grdb_op_t op, input logic [6:0] a,
      input logic [3:0] col, input logic [3:0] imm, input logic [6:0] pa);
      @(posedge aclk);
      cmd <= '{1'b1, op, a, col, imm, pa};
      @(negedge aclk);
      while (!cmd_ready) @(negedge aclk);
      @(posedge aclk);
      cmd <= '0;
      @(negedge aclk); // Outputs launched at the taking edge settle here
   endtask : cpu
   task automatic t_reset();
      rdc(12'h00C, 32'h0320);
      rdc(12'h010, 32'h00);
      rdc(12'h014, 32'h00);
   endtask : t_reset
   task automatic t_window();
      wrc(12'h010, 32'hF6, 4'h1);
      rdc(12'h010, 32'h36);
      rdc(12'h014, 32'h1B);
      wrc(12'h010, 32'h05, 4'h1); // Bit 0 of low pointer ignored
      cpu(OP_MEM_WR, 7'h25, 4'h0, 4'hA, 7'h00);
      cpu(OP_MEM_WR, 7'h10, 4'h0, 4'h3, 7'h00);
      cpu(OP_ADD, 7'h10, 4'h5, 4'h0, 7'h00);
      chk(cpu_rdata, 4'hD);
      rdc(12'h894, 32'hD);
      cpu(OP_LOAD, 7'h10, 4'h6, 4'h0, 7'h00);
      rdc(12'h898, 32'h3);
      cpu(OP_SUB, 7'h25, 4'h6, 4'h0, 7'h00);
      chk(cpu_rdata, 4'h6);
      rdc(12'h9FC, 32'h4);
      cpu(OP_STORE, 7'h11, 4'h6, 4'h0, 7'h00);
      rdc(12'h844, 32'h6);
      cpu(OP_MEM_RD, 7'h25, 4'h0, 4'h0, 7'h00);
      chk(cpu_rdata, 4'hD);
   endtask : t_window
   task automatic t_banks();
      wrc(12'hDE4, 32'h1, 4'h1); // Bank select through a bank-2 alias
      rdc(12'h9E4, 32'h1);
      cpu(OP_MEM_WR, 7'h30, 4'h0, 4'h7, 7'h00);
      rdc(12'hAC0, 32'h7);
      wrc(12'h9E4, 32'h0, 4'h1);
   endtask : t_banks
   task automatic t_periph();
      wrc(12'h00C, 32'hA5, 4'h1);
      cpu(OP_PUT, 7'h00, 4'h0, 4'h0, 7'h03);
      @(negedge aclk); // Strobe is seen by the model one edge later
      chk(u_per.low_rld, 8'hA5);
      wrc(12'h00C, 32'h5A, 4'h1);
      cpu(OP_PUT, 7'h00, 4'h0, 4'h0, 7'h04);
      @(negedge aclk);
      chk(u_per.high_rld, 8'h5A);
      cpu(OP_PUT, 7'h00, 4'h0, 4'h0, 7'h06);
      @(negedge aclk);
      chk(u_per.tmr_rld, 8'h5A);
      cpu(OP_PUT, 7'h00, 4'h0, 4'h0, 7'h05);
      cpu(OP_GET, 7'h00, 4'h0, 4'h0, 7'h03);
      rdc(12'h00C, 32'h03A5);
      cpu(OP_GET, 7'h00, 4'h0, 4'h0, 7'h05);
      rdc(12'h00C, {24'h3, CNT});
      cpu(OP_GET, 7'h00, 4'h0, 4'h0, 7'h06);
      rdc(12'h00C, {24'h3, CNT});
   endtask : t_periph
   task automatic t_table();
      wrc(12'h00C, 32'hFFFF, 4'h3);
      cpu(OP_PUT, 7'h00, 4'h0, 4'h0, 7'h40);
      rdc(12'h9D0, 32'h3);
      wrc(12'h00C, 32'h0, 4'h3);
      cpu(OP_GET, 7'h00, 4'h0, 4'h0, 7'h40);
      rdc(12'h00C, 32'h3FFF);
      cpu(OP_MOVT, 7'h00, 4'h0, 4'h0, 7'h00);
      chk(rom_addr, 14'h3FFF);
      rdc(12'h00C, {16'h0, KEY ^ 16'h3FFF});
   endtask : t_table
   task automatic t_errors();
      logic [31:0] x;
      logic [1:0] r;
      axi(1'b1, 12'h014, 32'h1, 4'hF, x, r);
      chk(r, 2'b10);
      axi(1'b0, 12'h00E, 32'h0, 4'h0, x, r);
      chk({x, r}, {32'h0, 2'b10});
      axi(1'b0, 12'h020, 32'h0, 4'h0, x, r);
      chk({x, r}, {32'h0, 2'b10});
   endtask : t_errors
   // Run limit well above the 160 or so cycles the tests need
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         wrap_up();
      end
   end
   initial begin
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset();
      t_window();
      t_banks();
      t_periph();
      t_table();
      t_errors();
      wrap_up();
   end
endmodule : tb_general_register_and_data_buffer
`default_nettype wire
